//--- inc/bwqm_pkg.sv
package bwqm_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // instruction codes
   localparam logic [7:0] OP_SET_WRAP = 8'h77;
   localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
   localparam logic [7:0] OP_EXIT_QUAD = 8'hf5;

   ////////////////////////////////////////////////////////////////////////////////
   // frame layout, counted in received bits
   localparam int SHIFT_W = 40;
   localparam int CNT_W = 6;
   localparam logic [5:0] OPCODE_END = 6'h08;
   localparam logic [5:0] WRAP_FRAME_END = 6'h28;
   localparam logic [5:0] STEP_SINGLE = 6'h01;
   localparam logic [5:0] STEP_QUAD = 6'h04;
   localparam int LANES = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // configuration field positions
   localparam int CFG3_W = 7;
   localparam int WRAP_DIS_BIT = 4;
   localparam int WRAP_SIZE_LSB = 5;
   localparam int WRAP_SIZE_MSB = 6;
   localparam int WRAP_FIELD_LSB = 4;
   localparam int WRAP_FIELD_MSB = 6;
   localparam int LAT_MSB = 3;
   localparam int CFG2_QUAD_BIT = 3;
   localparam int CFG1_QE_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // wrapped address generation
   localparam int ADDR_W = 32;
   localparam logic [31:0] GROUP_BASE_MASK = 32'h0000_0007;
   localparam logic [31:0] ADDR_ONE = 32'h0000_0001;

   ////////////////////////////////////////////////////////////////////////////////
   // mode transition timing
   localparam int CLK_MHZ = 125;
   localparam int TRANS_CNT_W = 12;
   localparam int NS_PER_US = 1000;
   localparam int MODE_ENTRY_TIME_NS_DEF = 1000;
   localparam int MODE_EXIT_TIME_NS_DEF = 1000;

   typedef enum logic [1:0] {EVT_NONE, EVT_SET_WRAP, EVT_ENTER, EVT_EXIT} bwqm_evt_type;
   typedef enum logic [1:0] {ST_OPCODE, ST_PAYLOAD, ST_IGNORE} bwqm_link_state_type;

endpackage : bwqm_pkg

//--- design/bwqm_sync.sv
`timescale 1ns/10ps
// two-stage level synchroniser, first stage feeds only the second
module bwqm_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta;

   // no reset: the value settles within two edges of clk
   always_ff @(posedge clk)
   begin
      meta <= din;
      dout <= meta;
   end

endmodule : bwqm_sync

//--- design/bwqm_wrap_addr.sv
`timescale 1ns/10ps
// byte address sequencer for one read, plain or wrapped inside an aligned group
module bwqm_wrap_addr (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic rd_start,
   input wire logic [bwqm_pkg::ADDR_W-1:0] rd_start_addr,
   input wire logic rd_advance,
   input wire logic wrap_enable,
   input wire logic [1:0] wrap_size,
   output logic [bwqm_pkg::ADDR_W-1:0] rd_cur_addr,
   output logic rd_wrap_active
);

   logic [bwqm_pkg::ADDR_W-1:0] group_mask;
   logic [bwqm_pkg::ADDR_W-1:0] next_rd_cur_addr;
   logic [bwqm_pkg::ADDR_W-1:0] incr;

   // group mask is latched at start so a mid-read change cannot break a group
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         rd_wrap_active <= 1'b0;
         group_mask <= bwqm_pkg::GROUP_BASE_MASK;
      end
      else if (rd_start)
      begin
         rd_wrap_active <= wrap_enable;
         // the base mask is or-ed back in so the low bits stay set for every size
         group_mask <= (bwqm_pkg::GROUP_BASE_MASK << wrap_size) | bwqm_pkg::GROUP_BASE_MASK;
      end
   end

   // low bits roll inside the group, upper bits hold the group
   always_comb
   begin
      incr = rd_cur_addr + bwqm_pkg::ADDR_ONE;
      if (rd_wrap_active)
         next_rd_cur_addr = (rd_cur_addr & ~group_mask) | (incr & group_mask);
      else
         next_rd_cur_addr = incr;
   end

   // first address is the addressed byte itself
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         rd_cur_addr <= '0;
      else if (rd_start)
         rd_cur_addr <= rd_start_addr;
      else if (rd_advance)
         rd_cur_addr <= next_rd_cur_addr;
   end

endmodule : bwqm_wrap_addr

//--- design/bwqm_ctrl.sv
`timescale 1ns/10ps
module bwqm_ctrl #(
   parameter int MODE_ENTRY_TIME_NS = bwqm_pkg::MODE_ENTRY_TIME_NS_DEF,
   parameter int MODE_EXIT_TIME_NS = bwqm_pkg::MODE_EXIT_TIME_NS_DEF
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic soft_reset,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic [3:0] spi_io_in,
   input wire logic [bwqm_pkg::CFG3_W-1:0] nonvolatile_config_three,
   input wire logic [7:0] nonvolatile_config_two,
   input wire logic [7:0] volatile_config_one,
   input wire logic reg_wr_config_three,
   input wire logic reg_wr_config_two,
   input wire logic [7:0] reg_wr_data,
   input wire logic rd_start,
   input wire logic rd_is_quad_io,
   input wire logic [bwqm_pkg::ADDR_W-1:0] rd_start_addr,
   input wire logic rd_advance,
   output logic [bwqm_pkg::CFG3_W-1:0] volatile_config_three,
   output logic four_wire_instruction_mode,
   output logic mode_transition_busy,
   output logic cmd_during_transition,
   output logic set_wrap_length_cmd,
   output logic enter_quad_instr_mode_cmd,
   output logic exit_quad_instr_mode_cmd,
   output logic [bwqm_pkg::ADDR_W-1:0] rd_cur_addr,
   output logic rd_wrap_active
);

   // least times, rounded up to whole cycles, never below one
   localparam int ENTRY_CYC_RAW =
      (MODE_ENTRY_TIME_NS * bwqm_pkg::CLK_MHZ + bwqm_pkg::NS_PER_US - 1) / bwqm_pkg::NS_PER_US;
   localparam int EXIT_CYC_RAW =
      (MODE_EXIT_TIME_NS * bwqm_pkg::CLK_MHZ + bwqm_pkg::NS_PER_US - 1) / bwqm_pkg::NS_PER_US;
   localparam logic [bwqm_pkg::TRANS_CNT_W-1:0] ENTRY_CYC =
      bwqm_pkg::TRANS_CNT_W'((ENTRY_CYC_RAW < 1) ? 1 : ENTRY_CYC_RAW);
   localparam logic [bwqm_pkg::TRANS_CNT_W-1:0] EXIT_CYC =
      bwqm_pkg::TRANS_CNT_W'((EXIT_CYC_RAW < 1) ? 1 : EXIT_CYC_RAW);

   ////////////////////////////////////////////////////////////////////////////////
   // link domain: frame shifter on the serial clock

   logic link_four_wire;
   logic frame_four_wire;
   logic [bwqm_pkg::CNT_W-1:0] bit_cnt;
   logic [bwqm_pkg::CNT_W-1:0] next_bit_cnt;
   logic [bwqm_pkg::CNT_W-1:0] step;
   logic [bwqm_pkg::SHIFT_W-1:0] shift;
   logic [bwqm_pkg::SHIFT_W-1:0] next_shift;
   bwqm_pkg::bwqm_link_state_type state;
   bwqm_pkg::bwqm_link_state_type next_state;
   logic fire;
   bwqm_pkg::bwqm_evt_type fire_kind;
   logic link_toggle;
   bwqm_pkg::bwqm_evt_type link_kind;
   logic [2:0] link_wrap;

   // the mode is quasi-static across frames: the host waits out the transition time with
   // chip select high, so a frame's first edge sees a settled value
   // a synchroniser on the serial clock could not follow it, as that clock is parked
   // between frames and would apply a new mode two edges late
   // limitation: a mode change inside a frame only acts from the next frame
   always_ff @(posedge spi_sck or posedge spi_cs_n)
   begin
      if (spi_cs_n)
         frame_four_wire <= 1'b0;
      else if (bit_cnt == '0)
         frame_four_wire <= four_wire_instruction_mode;
   end

   // first edge takes the live mode, later edges the value held for this frame
   // so the opcode of a four-wire frame is taken as nibbles from its first clock
   always_comb
   begin
      link_four_wire = (bit_cnt == '0) ? four_wire_instruction_mode : frame_four_wire;
   end

   // one bit per clock on io0, or a nibble per clock with io3 as msb
   always_comb
   begin
      step = link_four_wire ? bwqm_pkg::STEP_QUAD : bwqm_pkg::STEP_SINGLE;
      if (link_four_wire)
         next_shift = {shift[bwqm_pkg::SHIFT_W-bwqm_pkg::LANES-1:0], spi_io_in};
      else
         next_shift = {shift[bwqm_pkg::SHIFT_W-2:0], spi_io_in[0]};
      next_bit_cnt = bwqm_pkg::CNT_W'(bit_cnt + step);
   end

   // decode the opcode after eight bits, the wrap byte after forty
   always_comb
   begin
      next_state = state;
      fire = 1'b0;
      fire_kind = bwqm_pkg::EVT_NONE;
      unique case (state)
         bwqm_pkg::ST_OPCODE:
         begin
            if (next_bit_cnt == bwqm_pkg::OPCODE_END)
            begin
               next_state = bwqm_pkg::ST_IGNORE;
               if (next_shift[7:0] == bwqm_pkg::OP_SET_WRAP)
                  next_state = bwqm_pkg::ST_PAYLOAD;
               else if (next_shift[7:0] == bwqm_pkg::OP_ENTER_QUAD)
               begin
                  fire = 1'b1;
                  fire_kind = bwqm_pkg::EVT_ENTER;
               end
               else if (next_shift[7:0] == bwqm_pkg::OP_EXIT_QUAD)
               begin
                  fire = 1'b1;
                  fire_kind = bwqm_pkg::EVT_EXIT;
               end
            end
         end
         bwqm_pkg::ST_PAYLOAD:
         begin
            // 24 don't-care bits pass by, the last byte carries the wrap field
            if (next_bit_cnt == bwqm_pkg::WRAP_FRAME_END)
            begin
               next_state = bwqm_pkg::ST_IGNORE;
               fire = 1'b1;
               fire_kind = bwqm_pkg::EVT_SET_WRAP;
            end
         end
         bwqm_pkg::ST_IGNORE:
            next_state = bwqm_pkg::ST_IGNORE;
      endcase
   end

   // chip select high ends the frame; a cut-short frame leaves no effect
   always_ff @(posedge spi_sck or posedge spi_cs_n)
   begin
      if (spi_cs_n)
      begin
         bit_cnt <= '0;
         shift <= '0;
         state <= bwqm_pkg::ST_OPCODE;
      end
      else
      begin
         shift <= next_shift;
         state <= next_state;
         if (state != bwqm_pkg::ST_IGNORE)
            bit_cnt <= next_bit_cnt;
      end
   end

   // event word held stable with a toggle; frames are far longer than the crossing
   always_ff @(posedge spi_sck or negedge resetn)
   begin
      if (!resetn)
      begin
         link_toggle <= 1'b0;
         link_kind <= bwqm_pkg::EVT_NONE;
         link_wrap <= '0;
      end
      else if (fire && !spi_cs_n)
      begin
         link_toggle <= ~link_toggle;
         link_kind <= fire_kind;
         link_wrap <= next_shift[bwqm_pkg::WRAP_FIELD_MSB:bwqm_pkg::WRAP_FIELD_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // system domain: event reception

   logic sys_toggle;
   logic seen_toggle;
   logic evt_valid;
   logic evt_wrap_cmd;
   logic evt_enter;
   logic evt_exit;
   logic any_reset;

   bwqm_sync #(
      .WIDTH(1)
   ) u_evt_sync (
      .clk(clk_sys),
      .din(link_toggle),
      .dout(sys_toggle)
   );

   // link_kind and link_wrap settled before the toggle, so sampling them here is safe
   always_comb
   begin
      any_reset = !resetn || soft_reset;
      evt_valid = sys_toggle ^ seen_toggle;
      evt_wrap_cmd = evt_valid && (link_kind == bwqm_pkg::EVT_SET_WRAP);
      evt_enter = evt_valid && (link_kind == bwqm_pkg::EVT_ENTER);
      evt_exit = evt_valid && (link_kind == bwqm_pkg::EVT_EXIT);
   end

   // soft reset does not touch the handshake, so no event is replayed; an event arriving during soft reset is dropped
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         seen_toggle <= 1'b0;
      else
         seen_toggle <= sys_toggle;
   end

   // one-cycle decode pulses for the surrounding device
   always_ff @(posedge clk_sys)
   begin
      if (any_reset)
      begin
         set_wrap_length_cmd <= 1'b0;
         enter_quad_instr_mode_cmd <= 1'b0;
         exit_quad_instr_mode_cmd <= 1'b0;
      end
      else
      begin
         set_wrap_length_cmd <= evt_wrap_cmd;
         enter_quad_instr_mode_cmd <= evt_enter;
         exit_quad_instr_mode_cmd <= evt_exit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // configuration three: wrap field and latency code

   // register write wins over a wrap command landing in the same cycle
   always_ff @(posedge clk_sys)
   begin
      if (any_reset)
         volatile_config_three <= nonvolatile_config_three;
      else if (reg_wr_config_three)
         volatile_config_three <= reg_wr_data[bwqm_pkg::CFG3_W-1:0];
      else if (evt_wrap_cmd)
         volatile_config_three[bwqm_pkg::WRAP_FIELD_MSB:bwqm_pkg::WRAP_FIELD_LSB] <=
            link_wrap;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // four-wire instruction mode bit

   always_ff @(posedge clk_sys)
   begin
      if (any_reset)
         four_wire_instruction_mode <= nonvolatile_config_two[bwqm_pkg::CFG2_QUAD_BIT];
      else if (reg_wr_config_two)
         four_wire_instruction_mode <= reg_wr_data[bwqm_pkg::CFG2_QUAD_BIT];
      else if (evt_enter)
         four_wire_instruction_mode <= 1'b1;
      else if (evt_exit)
         four_wire_instruction_mode <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mode transition timer

   logic [bwqm_pkg::TRANS_CNT_W-1:0] trans_cnt;
   logic [bwqm_pkg::TRANS_CNT_W-1:0] next_trans_cnt;

   // busy covers the entry or exit time; commands are only flagged, not blocked
   always_comb
   begin
      next_trans_cnt = trans_cnt;
      if (evt_enter)
         next_trans_cnt = ENTRY_CYC;
      else if (evt_exit)
         next_trans_cnt = EXIT_CYC;
      else if (trans_cnt != '0)
         next_trans_cnt = trans_cnt - 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (any_reset)
      begin
         trans_cnt <= '0;
         mode_transition_busy <= 1'b0;
      end
      else
      begin
         trans_cnt <= next_trans_cnt;
         mode_transition_busy <= (next_trans_cnt != '0);
      end
   end

   // a command decoded while the timer runs breaks the host's waiting time
   always_ff @(posedge clk_sys)
   begin
      if (any_reset)
         cmd_during_transition <= 1'b0;
      else
         cmd_during_transition <= evt_valid && (trans_cnt != '0);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read address sequencing

   logic wrap_enable;

   // wrap needs a quad io read, quad enable or four-wire mode, and bit 4 clear
   always_comb
   begin
      wrap_enable = rd_is_quad_io
         && (volatile_config_one[bwqm_pkg::CFG1_QE_BIT] || four_wire_instruction_mode)
         && !volatile_config_three[bwqm_pkg::WRAP_DIS_BIT];
   end

   bwqm_wrap_addr u_wrap_addr (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .rd_start(rd_start),
      .rd_start_addr(rd_start_addr),
      .rd_advance(rd_advance),
      .wrap_enable(wrap_enable),
      .wrap_size(volatile_config_three[bwqm_pkg::WRAP_SIZE_MSB:bwqm_pkg::WRAP_SIZE_LSB]),
      .rd_cur_addr(rd_cur_addr),
      .rd_wrap_active(rd_wrap_active)
   );

endmodule : bwqm_ctrl

//--- sim/bwqm_ctrl_assertions.sv
`timescale 1ns/10ps
// port-level checks of the wrap and four-wire command block
module bwqm_ctrl_assertions (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic soft_reset,
   input wire logic [bwqm_pkg::CFG3_W-1:0] nonvolatile_config_three,
   input wire logic [7:0] nonvolatile_config_two,
   input wire logic [7:0] volatile_config_one,
   input wire logic reg_wr_config_three,
   input wire logic reg_wr_config_two,
   input wire logic [7:0] reg_wr_data,
   input wire logic rd_start,
   input wire logic rd_is_quad_io,
   input wire logic [bwqm_pkg::ADDR_W-1:0] rd_start_addr,
   input wire logic rd_advance,
   input wire logic [bwqm_pkg::CFG3_W-1:0] volatile_config_three,
   input wire logic four_wire_instruction_mode,
   input wire logic mode_transition_busy,
   input wire logic set_wrap_length_cmd,
   input wire logic enter_quad_instr_mode_cmd,
   input wire logic exit_quad_instr_mode_cmd,
   input wire logic [bwqm_pkg::ADDR_W-1:0] rd_cur_addr,
   input wire logic rd_wrap_active
);
   // one domain only, so clock and reset are given once
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // wrap decision as the read start should see it
   wire logic wrap_ok = rd_is_quad_io && !volatile_config_three[4]
      && (volatile_config_one[1] || four_wire_instruction_mode);
   wire logic no_wr = !reg_wr_config_three && !reg_wr_config_two;
////////////////////////////////////////
   property p_pulse_one;
      set_wrap_length_cmd |=> !set_wrap_length_cmd;
   endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("wrap pulse too long");
   property p_lat_kept;
      set_wrap_length_cmd |-> volatile_config_three[3:0] == $past(volatile_config_three[3:0], 2);
   endproperty
   a_lat_kept: assert property (p_lat_kept) else $error("latency changed by wrap");
   property p_enter_sets;
      enter_quad_instr_mode_cmd && !$past(reg_wr_config_two) |-> four_wire_instruction_mode;
   endproperty
   a_enter_sets: assert property (p_enter_sets) else $error("enter left mode off");
   property p_exit_clears;
      exit_quad_instr_mode_cmd && !$past(reg_wr_config_two) |-> !four_wire_instruction_mode;
   endproperty
   a_exit_clears: assert property (p_exit_clears) else $error("exit left mode on");
   property p_busy;
      enter_quad_instr_mode_cmd || exit_quad_instr_mode_cmd |-> mode_transition_busy;
   endproperty
   a_busy: assert property (p_busy) else $error("no busy after mode change");
   property p_reg_two;
      reg_wr_config_two && !soft_reset |=> four_wire_instruction_mode == $past(reg_wr_data[3]);
   endproperty
   a_reg_two: assert property (p_reg_two) else $error("mode write lost");
   property p_soft;
      soft_reset && no_wr |=> volatile_config_three == $past(nonvolatile_config_three)
         && four_wire_instruction_mode == $past(nonvolatile_config_two[3]);
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset reload wrong");
   property p_start;
      rd_start |=> rd_cur_addr == $past(rd_start_addr) && rd_wrap_active == $past(wrap_ok);
   endproperty
   a_start: assert property (p_start) else $error("read start wrong");
   property p_seq;
      !rd_wrap_active && rd_advance && !rd_start |=> rd_cur_addr == $past(rd_cur_addr) + 1;
   endproperty
   a_seq: assert property (p_seq) else $error("sequential step wrong");
   property p_in_group;
      rd_wrap_active && rd_advance && !rd_start |=>
         rd_wrap_active && rd_cur_addr[31:6] == $past(rd_cur_addr[31:6]);
   endproperty
   a_in_group: assert property (p_in_group) else $error("wrap left group");
   c_wrap: cover property (set_wrap_length_cmd);
   c_enter: cover property (enter_quad_instr_mode_cmd);
   c_wrapped: cover property (rd_wrap_active && rd_advance);
endmodule : bwqm_ctrl_assertions

bind bwqm_ctrl bwqm_ctrl_assertions u_chk (.clk_sys, .resetn, .soft_reset,
   .nonvolatile_config_three, .nonvolatile_config_two, .volatile_config_one,
   .reg_wr_config_three, .reg_wr_config_two, .reg_wr_data, .rd_start, .rd_is_quad_io,
   .rd_start_addr, .rd_advance, .volatile_config_three, .four_wire_instruction_mode,
   .mode_transition_busy,
   .set_wrap_length_cmd, .enter_quad_instr_mode_cmd, .exit_quad_instr_mode_cmd,
   .rd_cur_addr, .rd_wrap_active);

//--- sim/bwqm_host_model.sv
`timescale 1ns/10ps
// host controller: clock parked low outside frames, 64 ns link period
module bwqm_host_model (
   output logic spi_sck,
   output logic spi_cs_n,
   output logic [3:0] spi_io_in
);
   // start levels at time zero, chip select low ahead of its first rising edge
   initial
   begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b0;
      spi_io_in = 4'h5;
      // a clean rising edge of chip select clears the frame logic at start
      #2 spi_cs_n = 1'b1;
   end
   // d left aligned, n edges of 1 or 4 bits, msb first; a short n cuts the frame
   task automatic frame(input logic [39:0] d, input int n, input logic quad);
      logic [39:0] s;
      s = d;
      #5 spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         spi_io_in = quad ? s[39:36] : {3'b010, s[39]};
         s = quad ? s << 4 : s << 1;
         #32 spi_sck = 1'b1;
         #32 spi_sck = 1'b0;
      end
      #32 spi_cs_n = 1'b1;
      // released lines must not keep the last value, or a stale bit could pass
      spi_io_in = ~spi_io_in;
      #64;
   endtask : frame
endmodule : bwqm_host_model

//--- sim/tb.sv
`timescale 1ns/10ps
// self-checking bench for the wrap and four-wire command block
module tb;
   localparam logic [6:0] NV3 = 7'h13;
   // clock starts high so reset falls on the first falling edge, clear of the rising edge the system side samples on
   logic clk_sys = 1'b1;
   logic resetn = 1'b1;
   logic soft_reset = 1'b0;
   logic spi_sck, spi_cs_n;
   logic [3:0] spi_io_in;
   logic [7:0] nonvolatile_config_two = 8'h00;
   logic [7:0] volatile_config_one = 8'h02;
   logic reg_wr_config_three = 1'b0;
   logic reg_wr_config_two = 1'b0;
   logic [7:0] reg_wr_data = 8'h00;
   logic rd_start = 1'b0;
   logic rd_is_quad_io = 1'b1;
   logic [31:0] rd_start_addr = 32'h0000_0000;
   logic rd_advance = 1'b0;
   logic [6:0] volatile_config_three;
   logic four_wire_instruction_mode, set_wrap_length_cmd;
   logic enter_quad_instr_mode_cmd, exit_quad_instr_mode_cmd, rd_wrap_active;
   logic mode_transition_busy, cmd_during_transition;
   logic [31:0] rd_cur_addr;
   int n_mismatch = 0;
   int n_tests = 0;
   // system clock, 8 ns
   always #4 clk_sys = ~clk_sys;
   bwqm_host_model u_host (.spi_sck, .spi_cs_n, .spi_io_in);
   // short transition times keep the run brief
   bwqm_ctrl #(.MODE_ENTRY_TIME_NS(16), .MODE_EXIT_TIME_NS(16)) u_dut (.clk_sys, .resetn,
      .soft_reset, .spi_sck, .spi_cs_n, .spi_io_in, .nonvolatile_config_three(NV3),
      .nonvolatile_config_two, .volatile_config_one, .reg_wr_config_three, .reg_wr_config_two,
      .reg_wr_data, .rd_start, .rd_is_quad_io, .rd_start_addr, .rd_advance,
      .volatile_config_three, .four_wire_instruction_mode, .mode_transition_busy,
      .cmd_during_transition, .set_wrap_length_cmd, .enter_quad_instr_mode_cmd,
      .exit_quad_instr_mode_cmd, .rd_cur_addr, .rd_wrap_active);
////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // a frame with a bounded watch for the pulse of command k
   task automatic send(input logic [39:0] d, input int n, input logic q, input int k,
         input logic exp);
      logic seen;
      logic bsy;
      logic cdt;
      seen = 1'b0;
      bsy = 1'b0;
      cdt = 1'b0;
      fork
         u_host.frame(d, n, q);
         repeat (400)
         begin
            @(negedge clk_sys);
            seen |= (k == 0) ? set_wrap_length_cmd : (k == 1) ? enter_quad_instr_mode_cmd
               : exit_quad_instr_mode_cmd;
            bsy |= mode_transition_busy;
            cdt |= cmd_during_transition;
         end
      join
      chk("command pulse", exp, seen);
      chk("transition busy", (k != 0) && exp, bsy);
      chk("command in transition", 0, cdt);
   endtask : send
   task automatic wr(input logic three, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr_config_three = three;
      reg_wr_config_two = !three;
      reg_wr_data = d;
      @(negedge clk_sys);
      reg_wr_config_three = 1'b0;
      reg_wr_config_two = 1'b0;
      @(negedge clk_sys);
   endtask : wr
   // g is the group size, 0 for plain sequential
   task automatic rd(input logic [31:0] a, input int g, input int steps);
      logic [31:0] e;
      e = a;
      @(negedge clk_sys);
      rd_start = 1'b1;
      rd_start_addr = a;
      @(negedge clk_sys);
      rd_start = 1'b0;
      chk("wrap active", g != 0, rd_wrap_active);
      for (int i = 0; i < steps; i++)
      begin
         chk("read addr", e, rd_cur_addr);
         rd_advance = 1'b1;
         @(negedge clk_sys);
         e = (g == 0) ? e + 1 : (e & ~(g - 1)) | ((e + 1) & (g - 1));
      end
      rd_advance = 1'b0;
   endtask : rd
////////////////////////////////////////
   task automatic t_wrap_single;
      chk("cfg3 reset", NV3, volatile_config_three);
      chk("mode reset", 0, four_wire_instruction_mode);
      wr(1'b1, 8'h1f);
      send(40'h77_0000_00ac, 20, 1'b0, 0, 1'b0);
      chk("cfg3 cut", 7'h1f, volatile_config_three);
      send(40'h77_0000_00ac, 40, 1'b0, 0, 1'b1);
      chk("cfg3 wrap", 7'h2f, volatile_config_three);
      rd(32'h0000_010c, 16, 20);
      $display("test wrap single done");
   endtask : t_wrap_single
   task automatic t_quad;
      send(40'h38_0000_0000, 8, 1'b0, 1, 1'b1);
      chk("mode on", 1, four_wire_instruction_mode);
      send(40'h77_0000_0060, 10, 1'b1, 0, 1'b1);
      chk("cfg3 quad", 7'h6f, volatile_config_three);
      $display("test quad done");
   endtask : t_quad
   task automatic t_reads;
      logic [31:0] st [4] = '{32'h0000_1007, 32'h0000_100c, 32'h0000_101e, 32'h0000_102e};
      for (int c = 0; c < 4; c++)
      begin
         wr(1'b1, {1'b0, 2'(c), 5'h03});
         rd(st[c], 8 << c, (8 << c) + 2);
      end
      wr(1'b1, 8'h13);
      rd(32'h0000_2003, 0, 12);
      wr(1'b1, 8'h03);
      rd_is_quad_io = 1'b0;
      rd(32'h0000_2005, 0, 12);
      rd_is_quad_io = 1'b1;
      $display("test reads done");
   endtask : t_reads
   task automatic t_exit;
      send(40'hf5_0000_0000, 2, 1'b1, 2, 1'b1);
      chk("mode off", 0, four_wire_instruction_mode);
      wr(1'b0, 8'h08);
      chk("mode written", 1, four_wire_instruction_mode);
      wr(1'b0, 8'h00);
      chk("mode cleared", 0, four_wire_instruction_mode);
      $display("test exit done");
   endtask : t_exit
   task automatic t_soft;
      wr(1'b1, 8'h55);
      nonvolatile_config_two = 8'h08;
      soft_reset = 1'b1;
      @(negedge clk_sys);
      soft_reset = 1'b0;
      @(negedge clk_sys);
      chk("cfg3 soft", NV3, volatile_config_three);
      chk("mode soft", 1, four_wire_instruction_mode);
      $display("test soft reset done");
   endtask : t_soft
   task automatic summarize;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   // main sequence
   initial
   begin
      @(negedge clk_sys);
      resetn = 1'b0;
      repeat (10) @(negedge clk_sys);
      resetn = 1'b1;
      @(negedge clk_sys);
      t_wrap_single();
      t_quad();
      t_reads();
      t_exit();
      t_soft();
      summarize();
   end
   // watchdog, several times the expected run length
   initial
   begin
      #100000;
      n_mismatch++;
      summarize();
   end
endmodule : tb
